/* File: common/xca_defs.vh */
`ifndef XCA_DEFS_VH
`define XCA_DEFS_VH

// Memory decode
`define XCA_WORD_ADDR_W    4
`define XCA_ACK_ADDR       4'hF
`define XCA_SERVICED_INTERRUPT_NUMBER_W         4
// Lane placement
`define XCA_LANE_LOW       1'b0
`define XCA_LANE_HIGH      1'b1
// Memory width codes
`define XCA_WIDTH_8        2'h0
`define XCA_WIDTH_16       2'h1
`define XCA_WIDTH_32       2'h2
// Address extension sources
`define XCA_EXT_ADDR       2'h0
`define XCA_EXT_DMA        2'h1
`define XCA_EXT_TIMER      2'h2
`define XCA_EXT_SERIAL     2'h3
// Chip select sources
`define XCA_CS_HOST0       2'h0
`define XCA_CS_HOST1       2'h1
`define XCA_CS_CNTL0       2'h2
`define XCA_CS_CNTL1       2'h3
// Event pulse shaping
`define XCA_PULSE_COUNT    2
`define XCA_PULSE_HIGH_NS  200
`define XCA_CLK_PERIOD_NS  100
`define XCA_PULSE_CYCLES   ((`XCA_PULSE_HIGH_NS + `XCA_CLK_PERIOD_NS - 1) / `XCA_CLK_PERIOD_NS)
`endif

/* File: src/xca_sync.v */
`include "xca_defs.vh"
module xca_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock_in,
    input  wire             rst_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] level_out
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;
    reg [WIDTH-1:0] level_reg;
    integer i;

    // Change accepted once second and third stages agree
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
            stage3_reg <= {WIDTH{1'b0}};
            level_reg  <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_reg[i] <= stage3_reg[i];
                end
            end
        end
    end

    assign level_out = level_reg;
endmodule

/* File: src/xca_event_pulser.v */
`include "xca_defs.vh"
module xca_event_pulser #(
    parameter PULSES = `XCA_PULSE_COUNT,
    parameter HIGH_CYCLES = `XCA_PULSE_CYCLES
) (
    input  wire clock_in,
    input  wire rst_in,
    input  wire event_in,
    output wire busy_out,
    output wire pulse_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_HIGH = 2'h1;
    localparam ST_LOW  = 2'h2;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [7:0] time_reg;
    reg [7:0] time_next;
    reg [3:0] left_reg;
    reg [3:0] left_next;
    reg       pulse_reg;

    always @* begin
        state_next = state_reg;
        time_next  = time_reg;
        left_next  = left_reg;
        case (state_reg)
            ST_IDLE: begin
                if (event_in) begin
                    state_next = ST_HIGH;
                    time_next  = HIGH_CYCLES[7:0];
                    left_next  = PULSES[3:0];
                end
            end
            ST_HIGH: begin
                if (time_reg == 8'h01) begin
                    state_next = ST_LOW;
                    time_next  = HIGH_CYCLES[7:0];
                    left_next  = left_reg - 4'h1;
                end else begin
                    time_next = time_reg - 8'h01;
                end
            end
            ST_LOW: begin
                if (time_reg == 8'h01) begin
                    // Two pulses per interrupt so the host counter toggles 0 to 1
                    if (left_reg == 4'h0) begin
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_HIGH;
                        time_next  = HIGH_CYCLES[7:0];
                    end
                end else begin
                    time_next = time_reg - 8'h01;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            time_reg  <= 8'h00;
            left_reg  <= 4'h0;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            time_reg  <= time_next;
            left_reg  <= left_next;
            pulse_reg <= (state_next == ST_HIGH);
        end
    end

    assign pulse_out = pulse_reg;
    assign busy_out  = (state_reg != ST_IDLE);
endmodule

/* File: src/xca_adapter.v */
`include "xca_defs.vh"
module xca_adapter #(
    parameter EXT_W = 4
) (
    input  wire             clock_in,
    input  wire             rst_in,
    // Platform straps
    input  wire [1:0]       cs_source_in,
    input  wire [1:0]       ext_source_in,
    input  wire             lane_high_in,
    input  wire [1:0]       mem_width_in,
    input  wire             ack_via_memory_in,
    input  wire             pd_via_gpio_in,
    input  wire             pulse2_via_int_in,
    input  wire             clock_via_serial_in,
    input  wire             byte_enable_connect_in,
    // Host memory interface
    input  wire [1:0]       host_chip_selects_n_in,
    input  wire [`XCA_WORD_ADDR_W-1:0] host_addr_in,
    input  wire             host_write_n_in,
    input  wire             host_read_n_in,
    input  wire [31:0]      host_data_in,
    output wire [31:0]      host_data_out,
    output wire [31:0]      host_data_oe_n_out,
    input  wire [3:0]       host_byte_enables_n_in,
    // Host spare outputs
    input  wire [1:0]       card_control_outputs,
    input  wire [3:0]       dma_done_outputs,
    input  wire [1:0]       timer_pulse_outputs,
    input  wire [1:0]       serial_tx_frame_syncs_in,
    input  wire [1:0]       serial_tx_clocks,
    input  wire             host_interrupt_to_card_in,
    input  wire             host_ack_in,
    input  wire [`XCA_SERVICED_INTERRUPT_NUMBER_W-1:0] host_serviced_interrupt_number_in,
    input  wire             host_powerdown_in,
    input  wire             host_gpio_pd_in,
    // Card side events toward host
    input  wire             card_event_in,
    input  wire             card_interrupt_in,
    input  wire             card_extra_interrupt_in,
    output wire [1:0]       timer_event_inputs,
    output wire             first_card_interrupt,
    output wire             spare_interrupt_out,
    output wire             serial_rx_frame_sync_out,
    output wire             serial_clock_source_out,
    output wire             serial_clock_source_oe_n_out,
    output wire [3:0]       byte_enables_n_out,
    // Card user side
    output wire [3:0]       card_addr_out,
    output wire [EXT_W-1:0] card_addr_ext_out,
    output wire             card_select_out,
    output wire             card_write_out,
    output wire             card_read_out,
    input  wire [15:0]      card_mem_rdata_in,
    output wire [15:0]      card_mem_wdata_out,
    output wire [31:0]      card_wide_wdata_out,
    input  wire [31:0]      card_wide_rdata_in,
    output wire             interrupt_acknowledge,
    output wire [`XCA_SERVICED_INTERRUPT_NUMBER_W-1:0] serviced_interrupt_number,
    output wire             powerdown_indicator,
    output wire             second_timer_pulse,
    output wire             first_timer_pulse_out,
    output wire             card_clock_out,
    output wire [3:0]       status_inputs_out
);
    //----------
    // Synchronised host and card signals
    //----------
    wire [1:0]  cs_n_s;
    wire        wr_n_s;
    wire        rd_n_s;
    wire [1:0]  cntl_s;
    wire [3:0]  dma_s;
    wire [1:0]  tout_s;
    wire [1:0]  fsx_s;
    wire [1:0]  clkx_s;
    wire        hint_s;
    wire        ack_s;
    wire        pd_s;
    wire        gpd_s;
    wire        cev_s;
    wire        cint_s;
    wire        cx_s;
    wire [2:0]  unused_s;

    xca_sync #(
        .WIDTH (26)
    ) u_sync (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .async_in  ({host_chip_selects_n_in, host_write_n_in, host_read_n_in,
                     card_control_outputs, dma_done_outputs, timer_pulse_outputs,
                     serial_tx_frame_syncs_in, serial_tx_clocks,
                     host_interrupt_to_card_in, host_ack_in, host_powerdown_in,
                     host_gpio_pd_in, card_event_in, card_interrupt_in,
                     card_extra_interrupt_in, 3'h0}),
        .level_out ({cs_n_s, wr_n_s, rd_n_s, cntl_s, dma_s, tout_s, fsx_s, clkx_s,
                     hint_s, ack_s, pd_s, gpd_s, cev_s, cint_s, cx_s, unused_s})
    );

    //----------
    // Platform straps captured after reset
    //----------
    reg        cfg_done_reg;
    reg [1:0]  cs_src_reg;
    reg [1:0]  ext_src_reg;
    reg        lane_reg;
    reg [1:0]  width_reg;
    reg        ack_mem_reg;
    reg        pd_gpio_reg;
    reg        p2_int_reg;
    reg        clk_ser_reg;
    reg        be_con_reg;

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_done_reg <= 1'b0;
            cs_src_reg   <= `XCA_CS_HOST0;
            ext_src_reg  <= `XCA_EXT_ADDR;
            lane_reg     <= `XCA_LANE_LOW;
            width_reg    <= `XCA_WIDTH_32;
            ack_mem_reg  <= 1'b0;
            pd_gpio_reg  <= 1'b0;
            p2_int_reg   <= 1'b0;
            clk_ser_reg  <= 1'b0;
            be_con_reg   <= 1'b0;
        end else if (!cfg_done_reg) begin
            cfg_done_reg <= 1'b1;
            cs_src_reg   <= cs_source_in;
            ext_src_reg  <= ext_source_in;
            lane_reg     <= lane_high_in;
            width_reg    <= mem_width_in;
            ack_mem_reg  <= ack_via_memory_in;
            pd_gpio_reg  <= pd_via_gpio_in;
            p2_int_reg   <= pulse2_via_int_in;
            clk_ser_reg  <= clock_via_serial_in;
            be_con_reg   <= byte_enable_connect_in;
        end
    end

    //----------
    // Chip select and address extension
    //----------
    reg sel_w;
    always @* begin
        case (cs_src_reg)
            `XCA_CS_HOST0: sel_w = !cs_n_s[0];
            `XCA_CS_HOST1: sel_w = !cs_n_s[1];
            `XCA_CS_CNTL0: sel_w = cntl_s[0];
            `XCA_CS_CNTL1: sel_w = cntl_s[1];
            default:       sel_w = 1'b0;
        endcase
    end

    reg [EXT_W-1:0] ext_w;
    always @* begin
        ext_w = {EXT_W{1'b0}};
        case (ext_src_reg)
            `XCA_EXT_DMA:    ext_w = dma_s[EXT_W-1:0];
            `XCA_EXT_TIMER:  ext_w[1:0] = tout_s;
            `XCA_EXT_SERIAL: ext_w[3:0] = {clkx_s, fsx_s};
            default:         ext_w = {EXT_W{1'b0}};
        endcase
    end

    reg [3:0]       addr_reg;
    reg [EXT_W-1:0] ext_reg;
    reg             sel_reg;
    reg             wr_reg;
    reg             rd_reg;
    reg [31:0]      wdata_reg;
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg  <= 4'h0;
            ext_reg   <= {EXT_W{1'b0}};
            sel_reg   <= 1'b0;
            wr_reg    <= 1'b0;
            rd_reg    <= 1'b0;
            wdata_reg <= 32'h00000000;
        end else begin
            addr_reg  <= host_addr_in;
            ext_reg   <= ext_w;
            sel_reg   <= sel_w;
            wr_reg    <= sel_w && !wr_n_s;
            rd_reg    <= sel_w && !rd_n_s;
            wdata_reg <= host_data_in;
        end
    end

    //----------
    // Byte lane alignment
    //----------
    function [15:0] lane_pick;
        input [31:0] bus;
        input        high;
        input [1:0]  width;
        begin
            if (high) begin
                lane_pick = (width == `XCA_WIDTH_8) ? {8'h00, bus[31:24]} : bus[31:16];
            end else begin
                lane_pick = (width == `XCA_WIDTH_8) ? {8'h00, bus[7:0]} : bus[15:0];
            end
        end
    endfunction

    reg [31:0] rdata_w;
    always @* begin
        if (width_reg == `XCA_WIDTH_32) begin
            rdata_w = card_wide_rdata_in;
        end else if (lane_reg == `XCA_LANE_HIGH) begin
            // Narrow top bit lands on bus bit 31
            rdata_w = (width_reg == `XCA_WIDTH_8) ?
                      {card_mem_rdata_in[7:0], 24'h000000} :
                      {card_mem_rdata_in, 16'h0000};
        end else begin
            rdata_w = {16'h0000, card_mem_rdata_in};
        end
    end

    reg [31:0] rdata_reg;
    reg        drive_reg;
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= 32'h00000000;
            drive_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_w;
            drive_reg <= sel_w && !rd_n_s;
        end
    end

    assign host_data_out       = rdata_reg;
    assign host_data_oe_n_out  = {32{!drive_reg}};
    assign card_mem_wdata_out  = lane_pick(wdata_reg, lane_reg, width_reg);
    assign card_wide_wdata_out = wdata_reg;
    assign byte_enables_n_out  = be_con_reg ? host_byte_enables_n_in : 4'h0;

    //----------
    // Interrupt acknowledge and powerdown
    //----------
    reg                   ack_reg;
    reg [`XCA_SERVICED_INTERRUPT_NUMBER_W-1:0] serviced_interrupt_number_reg;
    wire mem_ack = sel_w && !wr_n_s && (host_addr_in == `XCA_ACK_ADDR);
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ack_reg  <= 1'b0;
            serviced_interrupt_number_reg <= {`XCA_SERVICED_INTERRUPT_NUMBER_W{1'b0}};
        end else if (ack_mem_reg) begin
            ack_reg <= mem_ack && !wr_reg;
            if (mem_ack && !wr_reg) begin
                serviced_interrupt_number_reg <= host_data_in[`XCA_SERVICED_INTERRUPT_NUMBER_W-1:0];
            end
        end else begin
            ack_reg  <= ack_s;
            serviced_interrupt_number_reg <= host_serviced_interrupt_number_in;
        end
    end

    reg pd_reg;
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pd_reg <= 1'b0;
        end else begin
            pd_reg <= pd_gpio_reg ? gpd_s : pd_s;
        end
    end

    //----------
    // Timers, clocks and status substitutes
    //----------
    reg p1_reg;
    reg p2_reg;
    reg ck_reg;
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            p1_reg <= 1'b0;
            p2_reg <= 1'b0;
            ck_reg <= 1'b0;
        end else begin
            p1_reg <= tout_s[0];
            p2_reg <= p2_int_reg ? hint_s : tout_s[1];
            ck_reg <= clk_ser_reg ? clkx_s[0] : tout_s[0];
        end
    end

    //----------
    // Events toward host
    //----------
    wire tinp_pulse;
    reg cev_d_reg;
    reg cx_d_reg;
    reg fsr_reg;
    reg int_reg;
    reg spare_reg;
    wire cev_edge = cev_s && !cev_d_reg;

    xca_event_pulser u_pulser (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .event_in  (cev_edge),
        .busy_out  (),
        .pulse_out (tinp_pulse)
    );
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cev_d_reg <= 1'b0;
            cx_d_reg  <= 1'b0;
            fsr_reg   <= 1'b0;
            int_reg   <= 1'b0;
            spare_reg <= 1'b0;
        end else begin
            cev_d_reg <= cev_s;
            cx_d_reg  <= cx_s;
            fsr_reg   <= cx_s && !cx_d_reg;
            int_reg   <= cint_s;
            spare_reg <= cev_s;
        end
    end

    assign timer_event_inputs = {2{tinp_pulse}};
    assign first_card_interrupt         = int_reg;
    assign spare_interrupt_out          = spare_reg;
    assign serial_rx_frame_sync_out     = fsr_reg;
    assign serial_clock_source_out      = 1'b0;
    assign serial_clock_source_oe_n_out = 1'b1;
    assign card_addr_out                = addr_reg;
    assign card_addr_ext_out            = ext_reg;
    assign card_select_out              = sel_reg;
    assign card_write_out               = wr_reg;
    assign card_read_out                = rd_reg;
    assign interrupt_acknowledge        = ack_reg;
    assign serviced_interrupt_number    = serviced_interrupt_number_reg;
    assign powerdown_indicator          = pd_reg;
    assign second_timer_pulse           = p2_reg;
    assign first_timer_pulse_out        = p1_reg;
    assign card_clock_out               = ck_reg;
    assign status_inputs_out            = {tout_s, dma_s[1:0]};
endmodule

/* File: sim/xca_checker_asserts.sv */
module xca_checker (
    input wire       clock_in,
    input wire       rst_in,
    input wire [1:0] cs_source_in,
    input wire       ack_via_memory_in,
    input wire       byte_enable_connect_in,
    input wire [1:0] host_chip_selects_n_in,
    input wire       host_write_n_in,
    input wire [3:0] host_byte_enables_n_in,
    input wire       card_event_in,
    input wire       card_extra_interrupt_in,
    input wire [1:0] timer_event_inputs,
    input wire       serial_rx_frame_sync_out,
    input wire       serial_clock_source_out,
    input wire       serial_clock_source_oe_n_out,
    input wire [3:0] byte_enables_n_out,
    input wire       card_write_out,
    input wire       interrupt_acknowledge,
    input wire       spare_interrupt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // ----------
    // Port relations
    // ----------
    a_write_taken: assert property (cs_source_in == 2'h0 && !host_chip_selects_n_in[0]
        && $fell(host_write_n_in) |-> ##[3:6] card_write_out)
        else $error("write lost");
    a_deselect_quiet: assert property ((cs_source_in[1] == 1'b0
        && host_chip_selects_n_in == 2'h3) [*8] |-> !card_write_out)
        else $error("stray write");
    a_be_pull: assert property (!$past(rst_in) |-> byte_enables_n_out ==
        (byte_enable_connect_in ? host_byte_enables_n_in : 4'h0))
        else $error("byte enables wrong");
    a_tinp_start: assert property ($rose(card_event_in) |-> ##[3:8] timer_event_inputs[0])
        else $error("event pulse missing");
    a_tinp_shape: assert property ($rose(timer_event_inputs[0]) |->
        timer_event_inputs[0] [*2] ##1 !timer_event_inputs[0] [*2])
        else $error("event pulse shape wrong");
    a_tinp_pair: assert property (timer_event_inputs[0] == timer_event_inputs[1])
        else $error("timer event inputs differ");
    a_spare_follow: assert property ($rose(card_event_in) |-> ##[2:6] spare_interrupt_out)
        else $error("spare interrupt missing");
    a_fsync_start: assert property ($rose(card_extra_interrupt_in) |->
        ##[3:6] serial_rx_frame_sync_out)
        else $error("frame sync edge missing");
    a_fsync_single: assert property (serial_rx_frame_sync_out |=> !serial_rx_frame_sync_out)
        else $error("frame sync too long");
    a_ack_single: assert property (ack_via_memory_in && interrupt_acknowledge
        |=> !interrupt_acknowledge)
        else $error("acknowledge too long");
    a_serial_clock_source_in_unused: assert property (serial_clock_source_oe_n_out
        && !serial_clock_source_out)
        else $error("clock source pin driven");
endmodule

bind xca_adapter xca_checker xca_checker_inst (.*);

/* File: sim/xca_host_model.sv */
module xca_host_model (
    input  wire         clock_in,
    output logic [1:0]  cs_n_out,
    output logic [3:0]  addr_out,
    output logic        wr_n_out,
    output logic        rd_n_out,
    output logic [31:0] data_out,
    output logic [3:0]  be_n_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {cs_n_out, addr_out, wr_n_out, rd_n_out, data_out, be_n_out} = {2'h3, 4'h0, 2'h3, 36'h0};
    end

    // ----------
    // Host access, strobe held well past the synchroniser delay
    // ----------
    task automatic start(input logic sel, input logic wr, input logic [3:0] a,
                         input logic [31:0] d, input logic [3:0] be_n);
        @(posedge clock_in);
        #1;
        cs_n_out = sel ? 2'h1 : 2'h2;
        addr_out = a;
        data_out = wr ? d : ~data_out;
        be_n_out = be_n;
        wr_n_out = !wr;
        rd_n_out = wr;
        repeat (8) @(posedge clock_in);
        #1;
    endtask

    // Released bus shows the inverse of its last value
    task automatic stop();
        {cs_n_out, wr_n_out, rd_n_out} = 4'hF;
        data_out = ~data_out;
        repeat (8) @(posedge clock_in);
        #1;
    endtask
endmodule

/* File: sim/tb_top.sv */
`include "xca_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_in, rst_in, lane_high_in, ack_via_memory_in, pd_via_gpio_in;
    logic        pulse2_via_int_in, clock_via_serial_in, byte_enable_connect_in;
    logic        host_write_n_in, host_read_n_in, host_interrupt_to_card_in, host_ack_in;
    logic        host_powerdown_in, host_gpio_pd_in, card_event_in, card_interrupt_in;
    logic        card_extra_interrupt_in, first_card_interrupt, spare_interrupt_out;
    logic        serial_rx_frame_sync_out, serial_clock_source_out, card_select_out;
    logic        serial_clock_source_oe_n_out, card_write_out, card_read_out;
    logic        interrupt_acknowledge, powerdown_indicator, second_timer_pulse;
    logic        first_timer_pulse_out, card_clock_out, tinp_prev;
    logic [1:0]  cs_source_in, ext_source_in, mem_width_in, host_chip_selects_n_in;
    logic [1:0]  card_control_outputs, timer_pulse_outputs, serial_tx_frame_syncs_in;
    logic [1:0]  serial_tx_clocks, timer_event_inputs;
    logic [3:0]  host_addr_in, host_byte_enables_n_in, dma_done_outputs, host_serviced_interrupt_number_in;
    logic [3:0]  byte_enables_n_out, card_addr_out, card_addr_ext_out;
    logic [3:0]  serviced_interrupt_number, status_inputs_out;
    logic [15:0] card_mem_rdata_in, card_mem_wdata_out;
    logic [31:0] host_data_in, host_data_out, host_data_oe_n_out, card_wide_wdata_out;
    logic [31:0] card_wide_rdata_in;
    logic [31:0] seed = 32'h6704;
    int          miscompares, tests_run, cycles, tinp_seen, fsync_seen;
    logic [3:0]  ack_q[$];

    xca_adapter xca_adapter_inst (.*);
    xca_host_model xca_host_model_inst (.clock_in(clock_in), .cs_n_out(host_chip_selects_n_in),
        .addr_out(host_addr_in), .wr_n_out(host_write_n_in), .rd_n_out(host_read_n_in),
        .data_out(host_data_in), .be_n_out(host_byte_enables_n_in));

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // ----------
    // Helpers and reference model
    // ----------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic reset_with(input logic [1:0] cs, input logic [1:0] ext, input logic hi,
                              input logic [1:0] w, input logic [4:0] f);
        @(posedge clock_in);
        #1;
        rst_in = 1'b1;
        {card_event_in, card_extra_interrupt_in} = 2'h0;
        {cs_source_in, ext_source_in, lane_high_in, mem_width_in} = {cs, ext, hi, w};
        {ack_via_memory_in, pd_via_gpio_in, pulse2_via_int_in, clock_via_serial_in,
         byte_enable_connect_in} = f;
        repeat (6) @(posedge clock_in);
        #1;
        rst_in = 1'b0;
        repeat (6) @(posedge clock_in);
        #1;
        {tinp_seen, fsync_seen} = 64'h0;
    endtask

    always @(negedge clock_in) begin
        cycles++;
        if (cycles > 5000) begin
            miscompares++;
            finish_test();
        end
        if (timer_event_inputs[0] === 1'b1 && tinp_prev === 1'b0)
            tinp_seen++;
        tinp_prev = timer_event_inputs[0];
        if (serial_rx_frame_sync_out === 1'b1)
            fsync_seen++;
        if (ack_via_memory_in && interrupt_acknowledge === 1'b1)
            check("serviced_interrupt_number_mem", serviced_interrupt_number, ack_q.pop_front());
    end

    // ----------
    // Scenarios
    // ----------
    initial begin
        logic        hi, b, k0;
        logic [1:0]  w;
        int          bits;
        logic [31:0] d, r, m;
        {rst_in, cs_source_in, ext_source_in, lane_high_in, mem_width_in, ack_via_memory_in,
         pd_via_gpio_in, pulse2_via_int_in, clock_via_serial_in, byte_enable_connect_in} = 13'h1000;
        {host_interrupt_to_card_in, host_ack_in, host_powerdown_in, host_gpio_pd_in,
         card_event_in, card_interrupt_in, card_extra_interrupt_in} = 7'h0;
        {card_control_outputs, dma_done_outputs, timer_pulse_outputs, serial_tx_frame_syncs_in,
         serial_tx_clocks, host_serviced_interrupt_number_in, card_mem_rdata_in, card_wide_rdata_in} = '0;
        for (int i = 0; i < 6; i++) begin
            hi = i[0];
            w = 2'(i / 2);
            reset_with({1'b0, hi}, {1'b0, hi}, hi, w, {4'h0, hi});
            check("oe_reset", host_data_oe_n_out, 32'hFFFFFFFF);
            bits = (w == `XCA_WIDTH_8) ? 8 : (w == `XCA_WIDTH_16) ? 16 : 32;
            m = (bits == 32) ? '1 : hi ? ~(32'hFFFFFFFF >> bits) : ~(32'hFFFFFFFF << bits);
            d = rnd();
            dma_done_outputs = d[3:0];
            xca_host_model_inst.start(!hi, 1'b1, d[7:4], d, d[11:8]);
            check("refused", card_write_out, 1'b0);
            xca_host_model_inst.stop();
            xca_host_model_inst.start(hi, 1'b1, d[7:4], d, d[11:8]);
            check("write", card_write_out & card_select_out, 1'b1);
            check("addr", card_addr_out, d[7:4]);
            check("ext", card_addr_ext_out, hi ? d[3:0] : 4'h0);
            check("be", byte_enables_n_out, hi ? d[11:8] : 4'h0);
            if (bits == 32)
                check("wide_w", card_wide_wdata_out, d);
            else
                check("narrow_w", card_mem_wdata_out & ~(16'hFFFF << bits),
                      hi ? d >> (32 - bits) : d & ~(32'hFFFFFFFF << bits));
            xca_host_model_inst.stop();
            r = rnd();
            {card_mem_rdata_in, card_wide_rdata_in} = {r[15:0], r};
            xca_host_model_inst.start(hi, 1'b0, r[7:4], r, 4'h0);
            check("read", host_data_out & m, (hi && bits < 32 ? r << (32 - bits) : r) & m);
            check("oe", host_data_oe_n_out & m, 32'h0);
            check("rd", card_read_out, 1'b1);
            xca_host_model_inst.stop();
        end
        for (int k = 0; k < 2; k++) begin
            k0 = k[0];
            reset_with(2'h0, 2'h0, 1'b0, 2'h2, {1'b0, {3{k0}}, 1'b0});
            for (int v = 0; v < 2; v++) begin
                b = v[0];
                r = rnd();
                {host_gpio_pd_in, host_interrupt_to_card_in, card_interrupt_in} = {3{b}};
                {host_ack_in, card_event_in, card_extra_interrupt_in} = {3{b}};
                {host_powerdown_in, timer_pulse_outputs, serial_tx_clocks} = {{3{!b}}, {2{b}}};
                {host_serviced_interrupt_number_in, dma_done_outputs, card_control_outputs} = r[9:0];
                serial_tx_frame_syncs_in = r[11:10];
                repeat (12) @(posedge clock_in);
                #1;
                check("pd", powerdown_indicator, k0 ? b : !b);
                check("pulse2", second_timer_pulse, k0 ? b : !b);
                check("clk", card_clock_out, k0 ? b : !b);
                check("tout", first_timer_pulse_out, !b);
                check("int_a", first_card_interrupt, b);
                check("interrupt_acknowledge", interrupt_acknowledge, b);
                check("serviced_interrupt_number_pin", serviced_interrupt_number, r[9:6]);
                check("status", status_inputs_out, {{2{!b}}, r[3:2]});
                check("spare", spare_interrupt_out, b);
                check("serial_clock_source_in_oe", serial_clock_source_oe_n_out, 1'b1);
            end
            repeat (8) @(posedge clock_in);
            check("tinp", tinp_seen, 2);
            check("fsync", fsync_seen, 1);
        end
        reset_with(2'h0, 2'h0, 1'b0, 2'h2, 5'h10);
        for (int j = 0; j < 3; j++) begin
            r = rnd();
            ack_q.push_back(r[3:0]);
            xca_host_model_inst.start(1'b0, 1'b1, `XCA_ACK_ADDR, r, 4'h0);
            {card_event_in, card_extra_interrupt_in} = 2'h0;
            xca_host_model_inst.stop();
            {card_event_in, card_extra_interrupt_in} = 2'h3;
        end
        repeat (20) @(posedge clock_in);
        check("ack_count", ack_q.size(), 0);
        check("tinp_n", tinp_seen, 6);
        check("fsync_n", fsync_seen, 3);
        finish_test();
    end
endmodule
